// ---- hw/brc_bridge_ctl.sv ----
// Routing, master-abort handling and error messaging of the secondary-bus bridge.
// Behaviour
// - The back-to-back enable bit reads 0, ignores writes, and no fast back-to-back cycle is issued.
// - The secondary reset bit reads 0 and software has no way to reset the secondary bus through it.
// - The abort mode bit reads 0; a master-aborted write is dropped and a read returns all ones.
// - The writable legacy graphics enable alone steers legacy VGA I/O and memory accesses; the mono bit does not affect routing.
// - With graphics enable and mono present both clear, VGA and MDA go to the hub link.
// - With graphics enable set, VGA goes to the secondary bus and MDA to the hub link.
// - The legacy I/O filter only affects I/O accesses already inside the I/O window.
// - With the filter clear, every non-legacy I/O access inside the window goes to the secondary bus.
// - With the filter set, the upper 768 bytes of each 1-KB block go to the hub link.
// - The system-error forward bit reads 0 and ignores writes.
// - With parity response clear, secondary parity errors raise no hub-link message.
// - With parity response set, parity errors raise a message when the bridge enable is set.
// - No secondary parity output pin exists; parity errors show only as hub-link messages.
// - With the target-abort bit clear, a received target abort raises no message.
// - With it set, a target abort raises a message when the bridge enable is set.
module brc_bridge_ctl (
	input  wire logic        sys_clk_in,
	input  wire logic        arst_n_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	input  wire logic        mono_adapter_present_in,
	input  wire logic        bridge_syserr_enable_in,
	input  wire logic        req_valid_in,
	input  wire logic        req_is_io_in,
	input  wire logic [31:0] req_addr_in,
	input  wire logic        io_window_hit_in,
	output logic             route_valid_out,
	output logic             route_secondary_out,
	input  wire logic        sec_master_abort_in,
	input  wire logic        sec_abort_is_read_in,
	output logic             abort_rd_done_out,
	output logic      [31:0] abort_rd_data_out,
	output logic             abort_wr_drop_out,
	input  wire logic        sec_addr_parity_err_in,
	input  wire logic        sec_data_parity_err_in,
	input  wire logic        sec_target_abort_in,
	output logic             hub_serr_msg_out,
	output logic             sec_fast_b2b_out,
	output logic             sec_reset_out
);
	import brc_pkg::*;
	`include "brc_params.svh"

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
			input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	function automatic brc_class_type classify(input logic io, input logic [31:0] a);
		brc_class_type c;
		c = BRC_CLS_NONE;
		if (io) begin
			if (in_range(a, `BRC_MDA_IO_LO, `BRC_MDA_IO_HI))
				c = BRC_CLS_MDA;
			else if (in_range(a, `BRC_VGA_IO_LO, `BRC_VGA_IO_HI))
				c = BRC_CLS_VGA;
		end else begin
			if (in_range(a, `BRC_MDA_MEM_LO, `BRC_MDA_MEM_HI))
				c = BRC_CLS_MDA;
			else if (in_range(a, `BRC_VGA_MEM_LO, `BRC_VGA_MEM_HI))
				c = BRC_CLS_VGA;
		end
		classify = c;
	endfunction : classify

	////////////////////////////////////////////////////////////////////////////////

	brc_state_type st_ff;
	brc_state_type nxt_st;
	brc_class_type req_class;
	logic          upper_768;
	logic          parity_err;

	assign req_class  = classify(req_is_io_in, req_addr_in);
	assign upper_768  = req_addr_in[9:8] != 2'h0;
	assign parity_err = sec_addr_parity_err_in | sec_data_parity_err_in;

	always_comb begin
		nxt_st = st_ff;
		// Register writes; only the writable bits are kept, the rest stay zero.
		if (reg_wr_in && reg_addr_in == `BRC_OFF_BRIDGE_CTL) begin
			nxt_st.legacy_gfx_ff  = reg_wdata_in[`BRC_BC_LEGACY_GFX];
			nxt_st.io_filter_ff   = reg_wdata_in[`BRC_BC_IO_FILTER];
			nxt_st.parity_resp_ff = reg_wdata_in[`BRC_BC_PARITY_RESP];
		end
		if (reg_wr_in && reg_addr_in == `BRC_OFF_ERROR_CMD)
			nxt_st.ta_syserr_ff = reg_wdata_in[`BRC_EC_TA_SYSERR];
		// Read data stands only in the cycle after the strobe.
		nxt_st.rdata_ff = 8'h00;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`BRC_OFF_BRIDGE_CTL: begin
					nxt_st.rdata_ff[`BRC_BC_LEGACY_GFX]  = st_ff.legacy_gfx_ff;
					nxt_st.rdata_ff[`BRC_BC_IO_FILTER]   = st_ff.io_filter_ff;
					nxt_st.rdata_ff[`BRC_BC_PARITY_RESP] = st_ff.parity_resp_ff;
				end
				`BRC_OFF_ERROR_CMD:
					nxt_st.rdata_ff[`BRC_EC_TA_SYSERR] = st_ff.ta_syserr_ff;
				default:
					nxt_st.rdata_ff = 8'h00;
			endcase
		end
		// Routing decision, one cycle after the request.
		nxt_st.route_valid_ff     = req_valid_in;
		nxt_st.route_secondary_ff = 1'b0;
		if (req_valid_in) begin
			if (req_class == BRC_CLS_MDA)
				nxt_st.route_secondary_ff = 1'b0;
			else if (req_class == BRC_CLS_VGA)
				nxt_st.route_secondary_ff = st_ff.legacy_gfx_ff;
			else if (req_is_io_in && io_window_hit_in)
				nxt_st.route_secondary_ff = !(st_ff.io_filter_ff && upper_768);
			else
				nxt_st.route_secondary_ff = 1'b0;
		end
		// Master abort always behaves as abort mode zero.
		nxt_st.abort_rd_done_ff = sec_master_abort_in && sec_abort_is_read_in;
		nxt_st.abort_wr_drop_ff = sec_master_abort_in && !sec_abort_is_read_in;
		nxt_st.abort_rd_data_ff = (sec_master_abort_in && sec_abort_is_read_in) ?
			`BRC_ABORT_RD_DATA : 32'h0000_0000;
		// Parity problems leave only through the hub-link message, never a pin.
		nxt_st.serr_msg_ff = bridge_syserr_enable_in &&
			((parity_err && st_ff.parity_resp_ff) ||
			 (sec_target_abort_in && st_ff.ta_syserr_ff));
		nxt_st.fast_b2b_ff  = 1'b0;
		nxt_st.sec_reset_ff = 1'b0;
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata_out       = st_ff.rdata_ff;
	assign route_valid_out     = st_ff.route_valid_ff;
	assign route_secondary_out = st_ff.route_secondary_ff;
	assign abort_rd_done_out   = st_ff.abort_rd_done_ff;
	assign abort_rd_data_out   = st_ff.abort_rd_data_ff;
	assign abort_wr_drop_out   = st_ff.abort_wr_drop_ff;
	assign hub_serr_msg_out    = st_ff.serr_msg_ff;
	assign sec_fast_b2b_out    = st_ff.fast_b2b_ff;
	assign sec_reset_out       = st_ff.sec_reset_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks. They observe the outputs against the inputs of the previous cycle.

	AST_NO_FAST_B2B: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		!sec_fast_b2b_out) else $error("fast back-to-back cycles enabled");

	AST_RESERVED_BC: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		reg_rd_in && reg_addr_in == `BRC_OFF_BRIDGE_CTL
		|=> reg_rdata_out[7:4] == 4'h0 && !reg_rdata_out[`BRC_BC_SYSERR_FWD])
		else $error("fixed or reserved bridge control bits read nonzero");

	AST_NO_SEC_RESET: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		!sec_reset_out) else $error("secondary reset asserted");

	AST_ABORT_READ: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		sec_master_abort_in && sec_abort_is_read_in |=> abort_rd_done_out &&
		abort_rd_data_out == `BRC_ABORT_RD_DATA && !abort_wr_drop_out)
		else $error("aborted read not completed with all ones");

	AST_ABORT_WRITE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		sec_master_abort_in && !sec_abort_is_read_in |=> abort_wr_drop_out && !abort_rd_done_out)
		else $error("aborted write not dropped");

	AST_MDA_TO_HUB: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_class == BRC_CLS_MDA |=> route_valid_out && !route_secondary_out)
		else $error("mono adapter access left the hub link");

	AST_VGA_ROUTE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_class == BRC_CLS_VGA |=> route_secondary_out == $past(st_ff.legacy_gfx_ff))
		else $error("legacy graphics routing wrong");

	AST_IO_FILTER: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_is_io_in && io_window_hit_in && req_class == BRC_CLS_NONE
		|=> route_secondary_out == !($past(st_ff.io_filter_ff) && $past(req_addr_in[9:8]) != 2'h0))
		else $error("window I/O routing wrong");

	AST_IO_OUTSIDE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && !io_window_hit_in && req_class == BRC_CLS_NONE |=> !route_secondary_out)
		else $error("access outside the window sent to the secondary bus");

	AST_SERR_MSG: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		hub_serr_msg_out == $past(bridge_syserr_enable_in && ((parity_err && st_ff.parity_resp_ff)
		|| (sec_target_abort_in && st_ff.ta_syserr_ff))))
		else $error("system error message does not match its cause");

	AST_TA_QUIET: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		sec_target_abort_in && !parity_err && !st_ff.ta_syserr_ff |=> !hub_serr_msg_out)
		else $error("target abort messaged while disabled");

	AST_RESERVED_EC: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		reg_rd_in && reg_addr_in == `BRC_OFF_ERROR_CMD |=> reg_rdata_out[7:1] == 7'h00)
		else $error("reserved error command bits read nonzero");

	////////////////////////////////////////////////////////////////////////////////
	// Each routing and error case is checked on its own so a wrong branch cannot hide.

	AST_VGA_MONO_SET: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_class == BRC_CLS_VGA && st_ff.legacy_gfx_ff
		&& mono_adapter_present_in |=> route_valid_out && route_secondary_out)
		else $error("graphics access with mono present not sent to the secondary bus");

	AST_VGA_MONO_CLEAR: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_class == BRC_CLS_VGA && st_ff.legacy_gfx_ff
		&& !mono_adapter_present_in |=> route_valid_out && route_secondary_out)
		else $error("graphics access without mono not sent to the secondary bus");

	AST_VGA_DISABLED: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_class == BRC_CLS_VGA && !st_ff.legacy_gfx_ff
		|=> route_valid_out && !route_secondary_out)
		else $error("graphics access left the hub link while disabled");

	AST_MDA_MONO_SET: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_class == BRC_CLS_MDA && mono_adapter_present_in
		|=> route_valid_out && !route_secondary_out)
		else $error("mono adapter access with mono present left the hub link");

	AST_IO_UNFILTERED: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_is_io_in && io_window_hit_in && req_class == BRC_CLS_NONE
		&& !st_ff.io_filter_ff |=> route_valid_out && route_secondary_out)
		else $error("window I/O not forwarded with the filter clear");

	AST_IO_FILTER_UPPER: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_is_io_in && io_window_hit_in && req_class == BRC_CLS_NONE
		&& st_ff.io_filter_ff && req_addr_in[9:8] != 2'h0 |=> !route_secondary_out)
		else $error("filtered upper block I/O sent to the secondary bus");

	AST_IO_FILTER_LOWER: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && req_is_io_in && io_window_hit_in && req_class == BRC_CLS_NONE
		&& st_ff.io_filter_ff && req_addr_in[9:8] == 2'h0 |=> route_secondary_out)
		else $error("filter blocked I/O in the lower block");

	AST_MEM_OTHER: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		req_valid_in && !req_is_io_in && req_class == BRC_CLS_NONE
		|=> route_valid_out && !route_secondary_out)
		else $error("non-legacy memory access sent to the secondary bus");

	AST_ROUTE_IDLE: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		!req_valid_in
		|=> !route_valid_out && !route_secondary_out)
		else $error("routing result without a request");

	AST_PARITY_QUIET: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		parity_err && !st_ff.parity_resp_ff && !sec_target_abort_in
		|=> !hub_serr_msg_out)
		else $error("parity error messaged while parity response is clear");

	AST_PARITY_REPORT: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		parity_err && st_ff.parity_resp_ff && bridge_syserr_enable_in
		|=> hub_serr_msg_out)
		else $error("parity error not messaged on the hub link");

	AST_SERR_GATED: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		!bridge_syserr_enable_in
		|=> !hub_serr_msg_out)
		else $error("system error message sent while the bridge enable is clear");

	AST_TA_REPORT: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		sec_target_abort_in && st_ff.ta_syserr_ff && bridge_syserr_enable_in
		|=> hub_serr_msg_out)
		else $error("target abort not messaged on the hub link");

	AST_ERR_IDLE: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		!parity_err && !sec_target_abort_in
		|=> !hub_serr_msg_out)
		else $error("system error message without a cause");

	AST_ABORT_IDLE: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		!sec_master_abort_in
		|=> !abort_rd_done_out && !abort_wr_drop_out && abort_rd_data_out == 32'h0000_0000)
		else $error("abort result without a master abort");

	AST_RDATA_IDLE: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		!reg_rd_in
		|=> reg_rdata_out == 8'h00)
		else $error("read data outside the read cycle");

	AST_RDATA_UNMAPPED: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		reg_rd_in && reg_addr_in != `BRC_OFF_BRIDGE_CTL && reg_addr_in != `BRC_OFF_ERROR_CMD
		|=> reg_rdata_out == 8'h00)
		else $error("unmapped offset read nonzero");

	AST_READ_BC: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		reg_rd_in && reg_addr_in == `BRC_OFF_BRIDGE_CTL
		|=> reg_rdata_out[`BRC_BC_LEGACY_GFX] == $past(st_ff.legacy_gfx_ff)
		&& reg_rdata_out[`BRC_BC_IO_FILTER] == $past(st_ff.io_filter_ff)
		&& reg_rdata_out[`BRC_BC_PARITY_RESP] == $past(st_ff.parity_resp_ff))
		else $error("bridge control read back wrong");

	AST_READ_EC: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		reg_rd_in && reg_addr_in == `BRC_OFF_ERROR_CMD
		|=> reg_rdata_out[`BRC_EC_TA_SYSERR] == $past(st_ff.ta_syserr_ff))
		else $error("error command read back wrong");

	AST_WRITE_BC: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		reg_wr_in && reg_addr_in == `BRC_OFF_BRIDGE_CTL
		|=> st_ff.legacy_gfx_ff == $past(reg_wdata_in[`BRC_BC_LEGACY_GFX])
		&& st_ff.io_filter_ff == $past(reg_wdata_in[`BRC_BC_IO_FILTER])
		&& st_ff.parity_resp_ff == $past(reg_wdata_in[`BRC_BC_PARITY_RESP]))
		else $error("bridge control write did not land");

	AST_WRITE_EC: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		reg_wr_in && reg_addr_in == `BRC_OFF_ERROR_CMD
		|=> st_ff.ta_syserr_ff == $past(reg_wdata_in[`BRC_EC_TA_SYSERR]))
		else $error("error command write did not land");

	AST_CTRL_HOLD: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		!reg_wr_in
		|=> $stable(st_ff.legacy_gfx_ff) && $stable(st_ff.io_filter_ff)
		&& $stable(st_ff.parity_resp_ff) && $stable(st_ff.ta_syserr_ff))
		else $error("control bits changed without a write");

	AST_UNMAPPED_WRITE: assert property (
		@(posedge sys_clk_in) disable iff (!arst_n_in)
		reg_wr_in && reg_addr_in != `BRC_OFF_BRIDGE_CTL && reg_addr_in != `BRC_OFF_ERROR_CMD
		|=> $stable(st_ff.legacy_gfx_ff) && $stable(st_ff.io_filter_ff)
		&& $stable(st_ff.parity_resp_ff) && $stable(st_ff.ta_syserr_ff))
		else $error("write to an unmapped offset changed a control bit");

endmodule : brc_bridge_ctl

// ---- pkg/brc_params.svh ----
// Register offsets, field positions, reset values and legacy address ranges of the bridge control.
`ifndef BRC_PARAMS_SVH
`define BRC_PARAMS_SVH

`define BRC_ADDR_W           8
`define BRC_DATA_W           8
`define BRC_OFF_BRIDGE_CTL   8'h3e
`define BRC_OFF_ERROR_CMD    8'h40
`define BRC_RST_BRIDGE_CTL   8'h00
`define BRC_RST_ERROR_CMD    8'h00

`define BRC_BC_BACK_TO_BACK  7
`define BRC_BC_SEC_RESET     6
`define BRC_BC_ABORT_MODE    5
`define BRC_BC_LEGACY_GFX    3
`define BRC_BC_IO_FILTER     2
`define BRC_BC_SYSERR_FWD    1
`define BRC_BC_PARITY_RESP   0
`define BRC_EC_TA_SYSERR     0

`define BRC_VGA_IO_LO        32'h0000_03c0
`define BRC_VGA_IO_HI        32'h0000_03df
`define BRC_MDA_IO_LO        32'h0000_03b0
`define BRC_MDA_IO_HI        32'h0000_03bb
`define BRC_VGA_MEM_LO       32'h000a_0000
`define BRC_VGA_MEM_HI       32'h000b_ffff
`define BRC_MDA_MEM_LO       32'h000b_0000
`define BRC_MDA_MEM_HI       32'h000b_7fff
`define BRC_ABORT_RD_DATA    32'hffff_ffff

`endif

// ---- pkg/brc_pkg.sv ----
// Types shared by the bridge routing and error control.
package brc_pkg;

	typedef enum logic [1:0] {
		BRC_CLS_NONE,
		BRC_CLS_VGA,
		BRC_CLS_MDA
	} brc_class_type;

	typedef struct packed {
		logic        legacy_gfx_ff;
		logic        io_filter_ff;
		logic        parity_resp_ff;
		logic        ta_syserr_ff;
		logic [7:0]  rdata_ff;
		logic        route_valid_ff;
		logic        route_secondary_ff;
		logic        abort_rd_done_ff;
		logic        abort_wr_drop_ff;
		logic [31:0] abort_rd_data_ff;
		logic        serr_msg_ff;
		logic        fast_b2b_ff;
		logic        sec_reset_ff;
	} brc_state_type;

endpackage : brc_pkg

// ---- verif/brc_sec_agent.sv ----
// Secondary-bus agent model that raises abort and error pulses.
module brc_sec_agent (
	input  wire logic       clk_in,
	input  wire logic       go_in,
	input  wire logic [2:0] ev_in,
	output logic            abort_out,
	output logic            is_read_out,
	output logic            addr_perr_out,
	output logic            data_perr_out,
	output logic            tabort_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{abort_out, is_read_out, addr_perr_out, data_perr_out, tabort_out} = '0;
	end
	// The read qualifier flips while idle, so a stale value never passes for a real one.
	always @(posedge clk_in) begin
		abort_out     <= go_in && ev_in < 3'h2;
		is_read_out   <= go_in ? ev_in == 3'h0 : ~is_read_out;
		addr_perr_out <= go_in && ev_in == 3'h2;
		data_perr_out <= go_in && ev_in == 3'h3;
		tabort_out    <= go_in && ev_in == 3'h4;
	end
endmodule : brc_sec_agent

// ---- verif/brc_bridge_ctl_bench.sv ----
// Self-checking bench for the bridge routing and error control.
module brc_bridge_ctl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rv = 0, io = 0, hit = 0;
	logic        mono = 0, sen = 0, go = 0;
	logic [7:0]  addr = '0, wd = '0, rdat, bc = '0, ec = '0;
	logic [31:0] ra = '0, ard;
	logic [2:0]  ev = '0;
	logic        rvo, rso, rdone, wdrop, serr, b2b, srst, ma, mrd, ap, dp, ta;
	int          errors = 0, samples_checked = 0;
	always #2 clk = ~clk;
	brc_sec_agent agent (.clk_in(clk), .go_in(go), .ev_in(ev), .abort_out(ma),
		.is_read_out(mrd), .addr_perr_out(ap), .data_perr_out(dp), .tabort_out(ta));
	brc_bridge_ctl dut (.sys_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
		.mono_adapter_present_in(mono), .bridge_syserr_enable_in(sen),
		.req_valid_in(rv), .req_is_io_in(io), .req_addr_in(ra), .io_window_hit_in(hit),
		.route_valid_out(rvo), .route_secondary_out(rso), .sec_master_abort_in(ma),
		.sec_abort_is_read_in(mrd), .abort_rd_done_out(rdone), .abort_rd_data_out(ard),
		.abort_wr_drop_out(wdrop), .sec_addr_parity_err_in(ap),
		.sec_data_parity_err_in(dp), .sec_target_abort_in(ta), .hub_serr_msg_out(serr),
		.sec_fast_b2b_out(b2b), .sec_reset_out(srst));
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic complete_run();
		if (errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	// The model keeps only the writable bits, so reserved and fixed bits stay zero.
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		if (a == 8'h3e) bc = d & 8'h0d;
		if (a == 8'h40) ec = d & 8'h01;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp(rdat, exp);
	endtask : rchk
	// Legacy ranges are decoded first; only other I/O falls to the window and filter.
	task automatic route(input logic i, input logic [31:0] a, input logic h);
		logic e;
		if (i ? (a >= 32'h3b0 && a <= 32'h3bb) : (a >= 32'hb0000 && a <= 32'hb7fff)) e = 1'b0;
		else if (i ? (a >= 32'h3c0 && a <= 32'h3df) : (a >= 32'ha0000 && a <= 32'hbffff))
			e = bc[3];
		else e = i & h & ~(bc[2] & |a[9:8]);
		@(posedge clk);
		rv <= 1'b1;
		io <= i;
		ra <= a;
		hit <= h;
		mono <= bc[3] & 1'($urandom);
		@(posedge clk);
		rv <= 1'b0;
		#1 cmp({rvo, rso}, {1'b1, e});
	endtask : route
	task automatic evchk(input logic [2:0] k, input logic [39:0] exp);
		@(posedge clk);
		go <= 1'b1;
		ev <= k;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1 cmp({rdone, wdrop, serr, ard}, exp);
	endtask : evchk
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic       i;
		logic [2:0] k;
		logic       s;
		i = 1'($urandom(32'hdbe0));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rchk(8'h3e, 8'h00);
		rchk(8'h40, 8'h00);
		wreg(8'h3e, 8'hff);
		wreg(8'h40, 8'hff);
		wreg(8'h3f, 8'hff);
		rchk(8'h3e, 8'h0d);
		rchk(8'h40, 8'h01);
		rchk(8'h3f, 8'h00);
		for (int n = 0; n < 300; n++) begin
			wreg(8'h3e, 8'($urandom));
			i = 1'($urandom);
			route(i, i ? ($urandom % 2 ? 32'h3b0 + $urandom % 48 : $urandom % 32'h1000)
				: 32'h98000 + $urandom % 32'h30000, 1'($urandom));
		end
		evchk(3'h0, {8'h04, 32'hffff_ffff});
		evchk(3'h1, {8'h02, 32'h0000_0000});
		for (int n = 0; n < 120; n++) begin
			@(posedge clk) sen <= 1'($urandom);
			wreg(8'h3e, 8'($urandom));
			wreg(8'h40, 8'($urandom));
			k = 3'h2 + 3'($urandom % 3);
			s = sen & ((k < 3'h4 & bc[0]) | (k == 3'h4 & ec[0]));
			evchk(k, {7'h00, s, 32'h0000_0000});
		end
		@(posedge clk) rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		bc = 8'h00;
		ec = 8'h00;
		rchk(8'h3e, bc);
		rchk(8'h40, ec);
		cmp({b2b, srst}, 2'b00);
		complete_run();
	end
endmodule : brc_bridge_ctl_bench
